// ### charger_host_model.sv
// Purpose: Host-side model of the enable pin and the open-drain power-good line
// Assumes: The power-good line has a pull-up on the host board
// Notes:   The enable pin follows the bench request one clock later
`timescale 1ns/100ps
`default_nettype none
module charger_host_model (
  input wire logic mclk_i, // Logic clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic en_req_i, // Bench request for the enable pin
  input wire logic pg_out_i, // Device open-drain data
  input wire logic pg_oe_i, // Device pulls the line
  output logic rev_en_o, // Reverse-operation enable pin
  output logic pg_line_o // Resolved power-good line
);
  // ==========================================================
  // Enable pin driver
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rev_en_o <= 1'b0;
    end else begin
      rev_en_o <= en_req_i;
    end
  end
  // ==========================================================
  // Pull-up holds the line high whenever the device lets go
  assign pg_line_o = pg_oe_i ? pg_out_i : 1'b1;
endmodule : charger_host_model
`default_nettype wire

// ### charger_pin_ctrl.sv
// Purpose: Power-good pin, reverse-mode decode and current-limit pin logic
// Assumes: Comparators are async levels; pin code in mV is on mclk_i
// Notes:   Registers over AXI4-Lite; one level interrupt output
// Function
// - Power good goes high after supply in window for 50 ms deglitch.
// - Power good drops at once below 3.2 V or above overvoltage rise.
// - Fault conditions force power good output low regardless of qualification.
// - With interrupt enable set, power good pulses on each charge status change.
// - OTG mode when select bit, OTG enable bit and pin are high.
// - Fast role swap when select bit, swap enable bit and pin are high.
// - Select bit low and pin high gives peak-supplement mode.
// - Pin above disable threshold: pin-derived limit ignored whatever enable bit.
// - Below threshold: minimum of pin and host limit if enabled, else host.
// - High impedance entered below 0.4 V, left only above 0.8 V.
// - Pin is sampled continuously; active limit follows it while enabled.
// - Pin limit equals pin voltage minus 1 V over 40 times sense resistance.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module charger_pin_ctrl
  import charger_pin_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYCLES_DEF
) (
  input wire logic mclk_i, // Logic clock, 200 MHz
  input wire logic arst_n_i, // Async reset, active low
  input wire logic supply_above_start_i, // Supply above 3.5 V
  input wire logic supply_below_uv_i, // Supply below 3.2 V
  input wire logic supply_below_ov_fall_i, // Supply below overvoltage fall threshold
  input wire logic supply_above_ov_rise_i, // Supply above overvoltage rise threshold
  input wire logic fault_i, // Fault that forces power good low
  input wire logic ilim_above_disable_i, // Pin above external limit disable threshold
  input wire logic ilim_below_hiz_enter_i, // Pin below 0.4 V
  input wire logic ilim_above_hiz_exit_i, // Pin above 0.8 V
  input wire logic reverse_operation_enable_i, // Reverse-operation enable pin
  input wire logic [11:0] ilim_pin_mv_i, // Sampled pin voltage in mV
  input wire logic charge_status_change_i, // One-cycle charge status change event
  output logic power_good_out_o, // Open-drain data, always low
  output logic power_good_oe_o, // High while the pin is pulled low
  output logic otg_mode_o, // OTG output mode
  output logic role_swap_mode_o, // Fast role swap enabled
  output logic peak_supplement_mode_o, // Peak-supplement mode
  output logic high_impedance_mode_o, // Low-quiescent high impedance mode
  output logic [15:0] input_current_target_o, // Active input limit in mA
  output logic irq_o, // Level interrupt
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read valid
  input wire logic s_axi_rready // AXI read ready
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [23:0] dgl_cnt;
    logic good;
    logic [7:0] pulse_cnt;
    logic pg_oe;
    logic high_impedance_mode;
    logic otg;
    logic frs;
    logic peak;
    logic ext_act;
    logic [15:0] act_lim;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] host_lim;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s;
  state_t next_s;
  logic [SY_W-1:0] sy;
  logic qual;
  logic drop;
  logic [15:0] pin_lim;

  // ==========================================================
  // Comparator synchronisers
  charger_pin_sync #(.W(SY_W)) u_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .async_i({reverse_operation_enable_i, ilim_above_hiz_exit_i, ilim_below_hiz_enter_i,
              ilim_above_disable_i, fault_i, supply_above_ov_rise_i,
              supply_below_ov_fall_i, supply_below_uv_i, supply_above_start_i}),
    .sync_o(sy)
  );

  // ==========================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = d[7:0];
    if (be[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  function automatic logic known_addr(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_HOST_LIMIT || a == ADDR_STATUS ||
           a == ADDR_ACTIVE_LIMIT || a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK;
  endfunction : known_addr

  // Pin mV to mA: 1000 * (V - 1000) / (40 * R), R in mOhm, R = 10 or 5
  always_comb begin
    logic [11:0] diff;
    logic [14:0] times5;
    diff = '0;
    times5 = '0;
    if (ilim_pin_mv_i > ILIM_OFFSET_MV) begin
      diff = ilim_pin_mv_i - ILIM_OFFSET_MV;
    end
    times5 = 15'(diff) * 15'd5;
    if (s.ctrl[CTRL_SENSE_5M]) begin
      pin_lim = 16'(times5);
    end else begin
      pin_lim = 16'(times5 >> 1);
    end
  end

  assign qual = sy[SY_START] & sy[SY_OVF];
  assign drop = sy[SY_UV] | sy[SY_OVR];

  // ==========================================================
  // Next state
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic w_fire;
    logic [15:0] lim;
    ev = '0;
    clr = '0;
    w_fire = 1'b0;
    lim = '0;
    next_s = s;
    // Supply qualification and deglitch
    if (drop) begin
      next_s.good = 1'b0;
      next_s.dgl_cnt = '0;
    end else if (!s.good) begin
      if (!qual) begin
        next_s.dgl_cnt = '0;
      end else if (s.dgl_cnt == 24'(DEGLITCH_CYCLES - 1)) begin
        next_s.good = 1'b1;
        next_s.dgl_cnt = '0;
      end else begin
        next_s.dgl_cnt = s.dgl_cnt + 24'h000001;
      end
    end
    // Interrupt pulse on the power good pin
    if (s.pulse_cnt != 8'h00) begin
      next_s.pulse_cnt = s.pulse_cnt - 8'h01;
    end
    if (s.ctrl[CTRL_PG_IRQ_EN] && charge_status_change_i) begin
      next_s.pulse_cnt = 8'(IRQ_PULSE_CYCLES);
    end
    next_s.pg_oe = !next_s.good || sy[SY_FAULT] || next_s.pulse_cnt != 8'h00;
    // Reverse-operation decode
    next_s.otg = s.ctrl[CTRL_REV_SEL] & s.ctrl[CTRL_OTG_EN] & sy[SY_REV];
    next_s.frs = s.ctrl[CTRL_REV_SEL] & s.ctrl[CTRL_FRS_EN] & sy[SY_REV];
    next_s.peak = !s.ctrl[CTRL_REV_SEL] & sy[SY_REV];
    // High impedance hysteresis
    if (sy[SY_HIZ_IN]) begin
      next_s.high_impedance_mode = 1'b1;
    end else if (sy[SY_HIZ_OUT]) begin
      next_s.high_impedance_mode = 1'b0;
    end
    // Input current limit selection, updated every cycle
    next_s.ext_act = !sy[SY_ENZ] & s.ctrl[CTRL_EXT_EN];
    lim = (pin_lim < s.host_lim) ? pin_lim : s.host_lim;
    next_s.act_lim = next_s.ext_act ? lim : s.host_lim;
    // Events
    ev[IRQ_PG_CHANGE] = next_s.good != s.good;
    ev[IRQ_CHG_STAT] = charge_status_change_i;
    ev[IRQ_HIZ_CHANGE] = next_s.high_impedance_mode != s.high_impedance_mode;
    ev[IRQ_MODE_CHANGE] = {next_s.otg, next_s.frs, next_s.peak} != {s.otg, s.frs, s.peak};
    // AXI write channel
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      w_fire = 1'b1;
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = known_addr(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (s.aw_addr == ADDR_CTRL) begin
        next_s.ctrl = CTRL_W'(merge16(16'(s.ctrl), s.wdata, s.wstrb));
      end else if (s.aw_addr == ADDR_HOST_LIMIT) begin
        next_s.host_lim = merge16(s.host_lim, s.wdata, s.wstrb);
      end else if (s.aw_addr == ADDR_IRQ_STATUS && s.wstrb[0]) begin
        clr = s.wdata[IRQ_W-1:0];
      end else if (s.aw_addr == ADDR_IRQ_MASK && s.wstrb[0]) begin
        next_s.irq_mask = s.wdata[IRQ_W-1:0];
      end
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_have && !next_s.bvalid && !w_fire;
    next_s.wready = !next_s.w_have && !next_s.bvalid && !w_fire;
    // Set wins over a simultaneous clear
    next_s.irq_st = (s.irq_st & ~clr) | ev;
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);
    // AXI read channel
    if (s_axi_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      if (s_axi_araddr == ADDR_CTRL) begin
        next_s.rdata = 32'(s.ctrl);
      end else if (s_axi_araddr == ADDR_HOST_LIMIT) begin
        next_s.rdata = 32'(s.host_lim);
      end else if (s_axi_araddr == ADDR_STATUS) begin
        next_s.rdata = 32'({s.ext_act, s.high_impedance_mode, s.peak, s.frs, s.otg, s.pg_oe, s.good});
      end else if (s_axi_araddr == ADDR_ACTIVE_LIMIT) begin
        next_s.rdata = 32'(s.act_lim);
      end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
        next_s.rdata = 32'(s.irq_st);
      end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
        next_s.rdata = 32'(s.irq_mask);
      end else begin
        next_s.rresp = RESP_SLVERR;
      end
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
      s.pg_oe <= 1'b1;
      s.ctrl <= CTRL_RST;
      s.host_lim <= HOST_LIMIT_RST;
      s.act_lim <= HOST_LIMIT_RST;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign power_good_out_o = 1'b0;
  assign power_good_oe_o = s.pg_oe;
  assign otg_mode_o = s.otg;
  assign role_swap_mode_o = s.frs;
  assign peak_supplement_mode_o = s.peak;
  assign high_impedance_mode_o = s.high_impedance_mode;
  assign input_current_target_o = s.act_lim;
  assign irq_o = s.irq;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence seq_irq_trigger;
    s.ctrl[CTRL_PG_IRQ_EN] && charge_status_change_i;
  endsequence
  sequence seq_pin_low_held;
    power_good_oe_o [*8];
  endsequence

  chk_pg_release: assert property ($rose(s.good) |->
    $past(qual) && $past(s.dgl_cnt) == 24'(DEGLITCH_CYCLES - 1))
    else $error("power good rose without full deglitch");
  chk_pg_drop: assert property (drop |=> !s.good && power_good_oe_o)
    else $error("power good not dropped on undervoltage or overvoltage");
  chk_fault_low: assert property (sy[SY_FAULT] |=> power_good_oe_o)
    else $error("fault did not pull power good low");
  chk_irq_pulse: assert property (seq_irq_trigger |=> seq_pin_low_held)
    else $error("charge status pulse too short");
  chk_otg_mode: assert property (otg_mode_o ==
    $past(s.ctrl[CTRL_REV_SEL] & s.ctrl[CTRL_OTG_EN] & sy[SY_REV]))
    else $error("otg mode decode wrong");
  chk_swap_mode: assert property (s.ctrl[CTRL_REV_SEL] && s.ctrl[CTRL_FRS_EN] && sy[SY_REV]
    |=> role_swap_mode_o)
    else $error("role swap not enabled");
  chk_peak_mode: assert property (!s.ctrl[CTRL_REV_SEL] && sy[SY_REV] |=>
    peak_supplement_mode_o && !otg_mode_o)
    else $error("peak supplement decode wrong");
  chk_ext_ignore: assert property (sy[SY_ENZ] |=>
    input_current_target_o == $past(s.host_lim))
    else $error("pin limit used above disable threshold");
  chk_ext_min: assert property (!sy[SY_ENZ] && s.ctrl[CTRL_EXT_EN] |=>
    input_current_target_o <= $past(s.host_lim) &&
    input_current_target_o <= $past(pin_lim))
    else $error("active limit not the smaller one");
  chk_hiz_hold: assert property (s.high_impedance_mode && !sy[SY_HIZ_OUT] |=> s.high_impedance_mode)
    else $error("high impedance left below exit level");
  chk_hiz_enter: assert property (sy[SY_HIZ_IN] |=> high_impedance_mode_o)
    else $error("high impedance not entered");
  chk_lim_conv: assert property (s.ctrl[CTRL_SENSE_5M] && ilim_pin_mv_i > ILIM_OFFSET_MV
    |-> 32'(pin_lim) * ILIM_GAIN * 5 == 32'(ilim_pin_mv_i - ILIM_OFFSET_MV) * 1000)
    else $error("pin limit conversion wrong");
  chk_dgl_restart: assert property (!s.good && !qual |=> s.dgl_cnt == 24'h000000)
    else $error("deglitch counter did not restart");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule : charger_pin_ctrl
`default_nettype wire

// ### charger_pin_pkg.sv
// Purpose: Shared constants for the charger pin control logic
// Assumes: 200 MHz logic clock, AXI4-Lite register access
// Notes:   Byte addresses, field positions, reset values and timing counts
package charger_pin_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned DEGLITCH_MS = 50;
  localparam int unsigned DEGLITCH_CYCLES_DEF = DEGLITCH_MS * CLK_MHZ * 1000;
  localparam int unsigned IRQ_PULSE_NS = 1000;
  localparam int unsigned IRQ_PULSE_CYCLES = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  // ==========================================================
  // Current limit conversion: pin mV minus offset, times 25 over sense mOhm
  localparam logic [11:0] ILIM_OFFSET_MV = 12'h3e8;
  localparam int unsigned ILIM_GAIN = 40;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HOST_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ACTIVE_LIMIT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // ==========================================================
  // Control fields
  localparam int CTRL_PG_IRQ_EN = 0;
  localparam int CTRL_REV_SEL = 1;
  localparam int CTRL_OTG_EN = 2;
  localparam int CTRL_FRS_EN = 3;
  localparam int CTRL_EXT_EN = 4;
  localparam int CTRL_SENSE_5M = 5;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] HOST_LIMIT_RST = 16'h0c80;
  // ==========================================================
  // Interrupt status bits
  localparam int IRQ_PG_CHANGE = 0;
  localparam int IRQ_CHG_STAT = 1;
  localparam int IRQ_HIZ_CHANGE = 2;
  localparam int IRQ_MODE_CHANGE = 3;
  localparam int IRQ_W = 4;
  // ==========================================================
  // Synchronised comparator vector positions
  localparam int SY_START = 0;
  localparam int SY_UV = 1;
  localparam int SY_OVF = 2;
  localparam int SY_OVR = 3;
  localparam int SY_FAULT = 4;
  localparam int SY_ENZ = 5;
  localparam int SY_HIZ_IN = 6;
  localparam int SY_HIZ_OUT = 7;
  localparam int SY_REV = 8;
  localparam int SY_W = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : charger_pin_pkg

// ### charger_pin_sync.sv
// Purpose: Two-stage synchroniser for asynchronous comparator levels
// Assumes: Inputs are slow levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module charger_pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i, // Logic clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [W-1:0] async_i, // Asynchronous levels
  output logic [W-1:0] sync_o // Synchronised levels
);
  logic [W-1:0] stage1;

  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        stage1[g] <= 1'b0;
        sync_o[g] <= 1'b0;
      end else begin
        stage1[g] <= async_i[g];
        sync_o[g] <= stage1[g];
      end
    end
  end
endmodule : charger_pin_sync
`default_nettype wire

// ### placeholder_end.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### test_charger_pin_ctrl.sv
// Purpose: Self-checking bench for the charger pin control logic
// Assumes: Short deglitch count; host model resolves the power-good line
// Notes:   Random limits come from a fixed-seed xorshift generator
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
      bad_count++; \
    end \
  end
module test_charger_pin_ctrl
  import charger_pin_pkg::*;
;
  localparam int unsigned DG = 20;
  logic mclk_i, arst_n_i, supply_above_start_i, supply_below_uv_i, supply_below_ov_fall_i;
  logic supply_above_ov_rise_i, fault_i, ilim_above_disable_i, ilim_below_hiz_enter_i;
  logic ilim_above_hiz_exit_i, reverse_operation_enable_i, charge_status_change_i;
  logic power_good_out_o, power_good_oe_o, otg_mode_o, role_swap_mode_o, irq_o, en_req;
  logic peak_supplement_mode_o, high_impedance_mode_o, pg_line, ext;
  logic [11:0] ilim_pin_mv_i, mv;
  logic [15:0] input_current_target_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] hz [7] = '{3'b101, 3'b001, 3'b010, 3'b000, 3'b101, 3'b111, 3'b010};
  int bad_count = 0;
  int comparisons = 0;

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  charger_pin_ctrl #(.DEGLITCH_CYCLES(DG)) u_charger_pin_ctrl (
    .mclk_i, .arst_n_i, .supply_above_start_i, .supply_below_uv_i, .supply_below_ov_fall_i,
    .supply_above_ov_rise_i, .fault_i, .ilim_above_disable_i, .ilim_below_hiz_enter_i,
    .ilim_above_hiz_exit_i, .reverse_operation_enable_i, .ilim_pin_mv_i,
    .charge_status_change_i, .power_good_out_o, .power_good_oe_o, .otg_mode_o,
    .role_swap_mode_o, .peak_supplement_mode_o, .high_impedance_mode_o,
    .input_current_target_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  charger_host_model u_charger_host_model (
    .mclk_i, .arst_n_i, .en_req_i(en_req), .pg_out_i(power_good_out_o),
    .pg_oe_i(power_good_oe_o), .rev_en_o(reverse_operation_enable_i), .pg_line_o(pg_line)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [15:0] exp_limit(input logic [11:0] v, input logic [15:0] host,
      input logic en, input logic dis, input logic r5);
    logic [15:0] d, pin;
    d = (v > 12'h3e8) ? {4'h0, v - 12'h3e8} : 16'h0000;
    pin = r5 ? d * 16'h0005 : (d * 16'h0005) >> 1;
    return (en && !dis && pin < host) ? pin : host;
  endfunction : exp_limit

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {supply_above_start_i, supply_below_uv_i, supply_below_ov_fall_i} = 3'b011;
    {supply_above_ov_rise_i, fault_i, ilim_above_disable_i} = 3'b000;
    {ilim_below_hiz_enter_i, ilim_above_hiz_exit_i, charge_status_change_i, en_req} = 4'h4;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    ilim_pin_mv_i = 12'h7d0;
    rnd = 32'hd2b23ee5;
    arst_n_i = 1'b0;
    cyc(10);
    arst_n_i <= 1'b1;
    cyc(1);
    `CHK(power_good_oe_o, 1'b1);
    `CHK(input_current_target_o, HOST_LIMIT_RST);
    `CHK({otg_mode_o, role_swap_mode_o, peak_supplement_mode_o, irq_o}, 4'h0);
    axi_rd(ADDR_CTRL, rd, rsp);
    `CHK(rd[5:0], CTRL_RST);
    axi_rd(8'h18, rd, rsp);
    `CHK({rd, rsp}, {32'h0, RESP_SLVERR});
    axi_wr(8'h1c, 32'hffff_ffff, rsp);
    `CHK(rsp, RESP_SLVERR);
    // Qualification, interrupted once part way through the deglitch
    {supply_below_uv_i, supply_above_start_i} <= 2'b01;
    cyc(15);
    `CHK(pg_line, 1'b0);
    supply_below_ov_fall_i <= 1'b0;
    cyc(3);
    supply_below_ov_fall_i <= 1'b1;
    cyc(15);
    `CHK(pg_line, 1'b0);
    cyc(15);
    `CHK(pg_line, 1'b1);
    for (int k = 0; k < 3; k++) begin
      if (k == 0) {supply_below_uv_i, supply_above_start_i} <= 2'b10;
      else if (k == 1) {supply_above_ov_rise_i, supply_below_ov_fall_i} <= 2'b10;
      else fault_i <= 1'b1;
      cyc(5);
      `CHK(pg_line, 1'b0);
      {supply_below_uv_i, supply_above_ov_rise_i, fault_i} <= 3'h0;
      {supply_below_ov_fall_i, supply_above_start_i} <= 2'b11;
      cyc(5);
      `CHK(pg_line, k == 2);
      cyc(30);
      `CHK(pg_line, 1'b1);
    end
    for (int k = 0; k < 2; k++) begin
      axi_wr(ADDR_CTRL, 32'(k), rsp);
      charge_status_change_i <= 1'b1;
      cyc(1);
      charge_status_change_i <= 1'b0;
      cyc(5);
      `CHK(pg_line, k == 0);
    end
    cyc(180);
    `CHK(pg_line, 1'b0);
    cyc(30);
    `CHK(pg_line, 1'b1);
    // Status bit raised while masked, then enabled and cleared
    axi_wr(ADDR_IRQ_MASK, 32'h0, rsp);
    axi_wr(ADDR_IRQ_STATUS, 32'hf, rsp);
    charge_status_change_i <= 1'b1;
    cyc(1);
    charge_status_change_i <= 1'b0;
    cyc(3);
    `CHK(irq_o, 1'b0);
    axi_rd(ADDR_IRQ_STATUS, rd, rsp);
    `CHK(rd[IRQ_CHG_STAT], 1'b1);
    axi_wr(ADDR_IRQ_MASK, 32'h1 << IRQ_CHG_STAT, rsp);
    cyc(2);
    `CHK(irq_o, 1'b1);
    axi_wr(ADDR_IRQ_STATUS, 32'h1 << IRQ_CHG_STAT, rsp);
    cyc(2);
    `CHK(irq_o, 1'b0);
    foreach (hz[j]) begin
      {ilim_below_hiz_enter_i, ilim_above_hiz_exit_i} <= hz[j][2:1];
      cyc(5);
      `CHK(high_impedance_mode_o, hz[j][0]);
    end
    axi_rd(ADDR_IRQ_STATUS, rd, rsp);
    `CHK(rd[IRQ_W-1:0], 4'h4);
    axi_wr(ADDR_IRQ_STATUS, 32'hf, rsp);
    for (int v = 0; v < 16; v++) begin
      axi_wr(ADDR_CTRL, {28'h0, v[3:1], 1'b0}, rsp);
      en_req <= v[0];
      cyc(8);
      `CHK(otg_mode_o, v[0] & v[1] & v[2]);
      `CHK(role_swap_mode_o, v[0] & v[1] & v[3]);
      `CHK(peak_supplement_mode_o, v[0] & !v[1]);
    end
    axi_rd(ADDR_IRQ_STATUS, rd, rsp);
    `CHK(rd[IRQ_W-1:0], 4'h8);
    axi_rd(ADDR_STATUS, rd, rsp);
    `CHK(rd[6:0], 7'h0d);
    // Low byte only: the upper byte keeps its reset value
    s_axi_wstrb <= 4'h1;
    axi_wr(ADDR_HOST_LIMIT, 32'h0000_ffff, rsp);
    s_axi_wstrb <= 4'hf;
    axi_rd(ADDR_HOST_LIMIT, rd, rsp);
    `CHK(rd[15:0], {HOST_LIMIT_RST[15:8], 8'hff});
    for (int i = 0; i < 12; i++) begin
      rnd = xs(rnd);
      mv = (i == 0) ? 12'h3e8 : (i == 1) ? 12'hfff : rnd[11:0];
      ext = rnd[28] | (i < 4);
      axi_wr(ADDR_HOST_LIMIT, {16'h0, rnd[27:12]}, rsp);
      axi_wr(ADDR_CTRL, {26'h0, rnd[30], ext, 4'h0}, rsp);
      `CHK(rsp, RESP_OKAY);
      ilim_pin_mv_i <= mv;
      ilim_above_disable_i <= rnd[29];
      cyc(5);
      `CHK(input_current_target_o, exp_limit(mv, rnd[27:12], ext, rnd[29], rnd[30]));
      ilim_pin_mv_i <= ~mv;
      cyc(3);
      `CHK(input_current_target_o, exp_limit(~mv, rnd[27:12], ext, rnd[29], rnd[30]));
      axi_rd(ADDR_ACTIVE_LIMIT, rd, rsp);
      `CHK(rd[15:0], exp_limit(~mv, rnd[27:12], ext, rnd[29], rnd[30]));
    end
    tally_and_finish();
  end
endmodule : test_charger_pin_ctrl
`default_nettype wire
